// ### accel_serial_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module accel_serial_port_test;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        self_test;
        logic [15:0] word;
        logic        chk;
        logic        axis;
        logic        shut;
    } accsp_row_t;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        sclk, cs_n, tsel_n, din, self_test, dout, oe, shut, axis, strb, done, ok, sd;
    logic [11:0] x, y, sample;
    logic [9:0]  temp;
    logic [31:0] w;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n_strb, n_done;
    accsp_row_t  rows [5];

    always #50 clk_i = ~clk_i;

    accsp_port accsp_port_i (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
        .accel_select_n_i(cs_n), .temp_select_n_i(tsel_n), .din_i(din),
        .self_test_in_i(self_test), .x_sample_i(x), .y_sample_i(y), .temp_data_i(temp),
        .dout_o(dout), .dout_oe_o(oe), .shutdown_o(shut), .axis_y_o(axis),
        .sample_strobe_o(strb), .conv_done_o(done), .sample_o(sample));

    accsp_host_model accsp_host_model_i (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(oe),
        .sclk_o(sclk), .accel_select_n_o(cs_n), .temp_select_n_o(tsel_n), .din_o(din));

    task automatic wrap_up();
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ceiling well above the ~10k cycles the frames need
    // pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk_i) begin
        cycles++;
        if (strb === 1'b1) n_strb++;
        if (done === 1'b1) n_done++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic run(input logic acc, input logic [7:0] ctrl, input int nclk);
        n_strb = 0;
        n_done = 0;
        accsp_host_model_i.frame(acc, ctrl, nclk, w, ok);
        repeat (6) @(negedge clk_i);
        chk("oe_in_frame", 32'h1, {31'h0, ok});
        chk("oe_released", 32'h0, {31'h0, oe});
        repeat (860) @(negedge clk_i);
    endtask

    initial begin
        self_test = 1'b0;
        x = 12'h123;
        y = 12'habc;
        temp = 10'h2a5;
        sd = 1'b0;
        rows[0] = '{8'h0c, 1'b0, 16'h0123, 1'b1, 1'b1, 1'b0};
        rows[1] = '{8'h84, 1'b1, 16'h0b89, 1'b1, 1'b0, 1'b0};
        rows[2] = '{8'h0d, 1'b0, 16'h0123, 1'b1, 1'b1, 1'b1};
        rows[3] = '{8'h0c, 1'b1, 16'h0123, 1'b1, 1'b1, 1'b0};
        rows[4] = '{8'h04, 1'b0, 16'h0abc, 1'b1, 1'b0, 1'b0};
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        chk("reset_outs", 32'h0, {oe, dout, shut, axis, sample});
        foreach (rows[k]) begin
            self_test = rows[k].self_test;
            run(1'b1, rows[k].ctrl, 16);
            if (rows[k].chk) chk("word", {16'h0, rows[k].word}, w);
            if (rows[k].chk) chk("sample", {20'h0, rows[k].word[11:0]}, {20'h0, sample});
            chk("strobes", {31'h0, ~sd}, n_strb);
            chk("done", 32'h1, n_done);
            chk("axis", {31'h0, rows[k].axis}, {31'h0, axis});
            chk("shutdown", {31'h0, rows[k].shut}, {31'h0, shut});
            sd = rows[k].shut;
        end
        // select kept low: second conversion follows with no gap
        run(1'b1, 8'h04, 32);
        chk("b2b_word", 32'h0123_0123, w);
        chk("b2b_done", 32'h2, n_done);
        chk("b2b_strobes", 32'h2, n_strb);
        run(1'b0, 8'h00, 16);
        chk("temp_word", 32'h54a0, w);
        chk("temp_strobes", 32'h0, n_strb);
        chk("temp_ctrl", 32'h0, {30'h0, axis, shut});
        // early abort: partial control word must not land
        run(1'b1, 8'h05, 8);
        chk("abort_shutdown", 32'h0, {31'h0, shut});
        chk("abort_done", 32'h0, n_done);
        // reset in mid-run from a shutdown, Y-axis state
        run(1'b1, 8'h0d, 16);
        chk("pre_reset_shutdown", 32'h1, {31'h0, shut});
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("mid_reset_outs", 32'h0, {oe, dout, shut, axis, sample});
        reset_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("post_reset_outs", 32'h0, {oe, dout, shut, axis, sample});
        run(1'b1, 8'h04, 16);
        chk("post_reset_word", 32'h0123, w);
        chk("post_reset_done", 32'h1, n_done);
        wrap_up();
    end
endmodule // accel_serial_port_test
`default_nettype wire

// ### accsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module accsp_host_model (
    input  wire logic clk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      sclk_o,
    output logic      accel_select_n_o,
    output logic      temp_select_n_o,
    output logic      din_o
);
    logic last_q;
    initial begin
        sclk_o = 1'b0;
        accel_select_n_o = 1'b1;
        temp_select_n_o = 1'b1;
        din_o = 1'b0;
        last_q = 1'b0;
    end
    // no keeper on the data line: released level reads inverted
    always @(posedge clk_i) if (dout_oe_i) last_q <= dout_i;
    task automatic hwait(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // serial clock stands low outside frames; data read late in the high phase
    task automatic frame(input logic acc, input logic [7:0] ctrl, input int nclk,
                         output logic [31:0] word, output logic oe_ok);
        word = 32'h0;
        oe_ok = 1'b1;
        @(negedge clk_i);
        if (acc) accel_select_n_o = 1'b0;
        else temp_select_n_o = 1'b0;
        hwait(4);
        for (int i = 0; i < nclk; i++) begin
            din_o = (i % 16 < 8) ? ctrl[7 - i % 16] : 1'b0;
            hwait(4);
            sclk_o = 1'b1;
            hwait(4);
            word = {word[30:0], dout_oe_i ? dout_i : ~last_q};
            oe_ok = oe_ok & dout_oe_i;
            sclk_o = 1'b0;
        end
        hwait(4);
        accel_select_n_o = 1'b1;
        temp_select_n_o = 1'b1;
        din_o = 1'b0;
    endtask
endmodule // accsp_host_model
`default_nettype wire

// ### accsp_pkg.sv
// Behaviour
// - temperature select low frames one serial readout of the temperature result.
// - serial output advances to its next bit on each falling serial clock edge.
// - serial input is shifted into the control word on rising serial clock edges.
// - acceleration select falling starts a conversion and frames its readout.
// - conversion steps only on the host serial clock, no internal oscillator.
// - selected axis is sampled on the second rising edge after select falls.
// - one conversion spans 16 serial clocks, all supplied within the frame.
// - acceleration select rising releases the serial output to high impedance.
// - select still low after 16 clocks starts the next conversion at once.
// - control bit 7 is accepted and has no effect.
// - control bit 3 picks the axis: 0 is X, 1 is Y.
// - control bit 0 picks the mode: 0 normal, 1 power-down.
// - stored control contents are kept through shutdown.
// - mode changes at control update; wake happens on the 16th rising edge.
// - self-test input high adds about 205 LSB to the converted result.
package accsp_pkg;

    // synchroniser lanes
    localparam int ACCSP_SYNC_W    = 5;
    localparam int ACCSP_LANE_SCLK = 0;
    localparam int ACCSP_LANE_CS   = 1;
    localparam int ACCSP_LANE_TSEL     = 2;
    localparam int ACCSP_LANE_DIN      = 3;
    localparam int ACCSP_LANE_SELFTEST = 4;

    localparam int ACCSP_FRAME_BITS = 16;
    localparam int ACCSP_DATA_W     = 12;
    localparam int ACCSP_TEMP_W     = 10;
    localparam int ACCSP_TEMP_PAD   = 5;

    localparam logic [3:0] ACCSP_SAMPLE_EDGE = 4'h1;
    localparam logic [3:0] ACCSP_CTRL_EDGES  = 4'h8;
    localparam logic [3:0] ACCSP_LAST_EDGE   = 4'hf;
    localparam logic [3:0] ACCSP_TOP_BIT     = 4'hf;

    localparam int         ACCSP_SELFTEST_LSB = 32'h0000_00cd;
    localparam logic [7:0] ACCSP_CTRL_RESET = 8'h04;

    typedef struct packed {
        logic       ignored_bit;
        logic [2:0] zero_hi;
        logic       axis_select_bit;
        logic       one_bit;
        logic       zero_lo;
        logic       power_mode_bit;
    } accsp_ctrl_t;

    typedef enum logic [3:0] {
        ACCSP_IDLE      = 4'b0001,
        ACCSP_ACCEL     = 4'b0010,
        ACCSP_TEMP      = 4'b0100,
        ACCSP_TEMP_HOLD = 4'b1000
    } accsp_phase_t;

endpackage : accsp_pkg

// ### accsp_port.sv
`timescale 1ns/10ps
`default_nettype none
module accsp_port #(
    parameter int DATA_W = accsp_pkg::ACCSP_DATA_W
) (
    input  wire logic                            clk_i,
    input  wire logic                            reset_i,
    input  wire logic                            sclk_i,
    input  wire logic                            accel_select_n_i,
    input  wire logic                            temp_select_n_i,
    input  wire logic                            din_i,
    input  wire logic                            self_test_in_i,
    input  wire logic [DATA_W-1:0]               x_sample_i,
    input  wire logic [DATA_W-1:0]               y_sample_i,
    input  wire logic [accsp_pkg::ACCSP_TEMP_W-1:0] temp_data_i,
    output logic                                 dout_o,
    output logic                                 dout_oe_o,
    output logic                                 shutdown_o,
    output logic                                 axis_y_o,
    output logic                                 sample_strobe_o,
    output logic                                 conv_done_o,
    output logic [DATA_W-1:0]                    sample_o
);

    // bit 14 leaves on the first fall, before the sample edge, so it must be padding
    if (DATA_W < 1 || DATA_W > accsp_pkg::ACCSP_FRAME_BITS - 2) begin : g_bad_width
        $error("accsp_port: DATA_W must leave two leading zeros in a frame");
    end

    typedef struct packed {
        logic [accsp_pkg::ACCSP_SYNC_W-1:0]     sync1;
        logic [accsp_pkg::ACCSP_SYNC_W-1:0]     sync2;
        logic [accsp_pkg::ACCSP_SYNC_W-1:0]     prev;
        accsp_pkg::accsp_phase_t                phase;
        logic [3:0]                             rise_cnt;
        logic [3:0]                             fall_cnt;
        logic [7:0]                             shift;
        accsp_pkg::accsp_ctrl_t                 ctrl;
        logic [DATA_W-1:0]                      sample;
        logic [accsp_pkg::ACCSP_FRAME_BITS-1:0] temp_word;
        logic                                   dout;
        logic                                   strobe;
        logic                                   done;
    } accsp_state_t;

    accsp_state_t q;
    accsp_state_t d;
    logic         sclk_rise;
    logic         sclk_fall;
    logic         cs_fell;
    logic         tsel_fell;
    logic [3:0]   fall_next;
    logic [accsp_pkg::ACCSP_FRAME_BITS-1:0] accel_word;
    logic [DATA_W-1:0] axis_val;

    always_comb begin
        // edges only from second stage onward; first stage feeds nothing else
        sclk_rise = q.sync2[accsp_pkg::ACCSP_LANE_SCLK] & ~q.prev[accsp_pkg::ACCSP_LANE_SCLK];
        sclk_fall = ~q.sync2[accsp_pkg::ACCSP_LANE_SCLK] & q.prev[accsp_pkg::ACCSP_LANE_SCLK];
        cs_fell   = ~q.sync2[accsp_pkg::ACCSP_LANE_CS] & q.prev[accsp_pkg::ACCSP_LANE_CS];
        tsel_fell = ~q.sync2[accsp_pkg::ACCSP_LANE_TSEL] & q.prev[accsp_pkg::ACCSP_LANE_TSEL];
        fall_next = q.fall_cnt + 4'h1;
        accel_word = {{(accsp_pkg::ACCSP_FRAME_BITS - DATA_W){1'b0}}, q.sample};
        axis_val  = q.ctrl.axis_select_bit ? y_sample_i : x_sample_i;
        if (q.sync2[accsp_pkg::ACCSP_LANE_SELFTEST]) begin
            axis_val = axis_val + DATA_W'(accsp_pkg::ACCSP_SELFTEST_LSB);
        end
        d        = q;
        d.sync1  = {self_test_in_i, din_i, temp_select_n_i, accel_select_n_i, sclk_i};
        d.sync2  = q.sync1;
        d.prev   = q.sync2;
        d.strobe = 1'b0;
        d.done   = 1'b0;
        unique case (q.phase)
            accsp_pkg::ACCSP_IDLE: begin
                // a select falling while the other is low is ignored
                if (cs_fell && q.sync2[accsp_pkg::ACCSP_LANE_TSEL]) begin
                    d.phase    = accsp_pkg::ACCSP_ACCEL;
                    d.rise_cnt = 4'h0;
                    d.fall_cnt = 4'h0;
                    d.dout     = accel_word[accsp_pkg::ACCSP_TOP_BIT];
                end else if (tsel_fell && q.sync2[accsp_pkg::ACCSP_LANE_CS]) begin
                    d.phase     = accsp_pkg::ACCSP_TEMP;
                    d.rise_cnt  = 4'h0;
                    d.fall_cnt  = 4'h0;
                    d.temp_word = {1'b0, temp_data_i, {accsp_pkg::ACCSP_TEMP_PAD{1'b0}}};
                    d.dout      = 1'b0;
                end
            end
            accsp_pkg::ACCSP_ACCEL: begin
                if (q.sync2[accsp_pkg::ACCSP_LANE_CS]) begin
                    d.phase = accsp_pkg::ACCSP_IDLE;
                end else begin
                    if (sclk_rise) begin
                        d.rise_cnt = q.rise_cnt + 4'h1;
                        if (q.rise_cnt < accsp_pkg::ACCSP_CTRL_EDGES) begin
                            d.shift = {q.shift[6:0], q.sync2[accsp_pkg::ACCSP_LANE_DIN]};
                        end
                        if (q.rise_cnt == accsp_pkg::ACCSP_SAMPLE_EDGE &&
                            !q.ctrl.power_mode_bit) begin
                            d.sample = axis_val;
                            d.strobe = 1'b1;
                        end
                        if (q.rise_cnt == accsp_pkg::ACCSP_LAST_EDGE) begin
                            // whole word stored, bit 7 kept but unused
                            d.ctrl = accsp_pkg::accsp_ctrl_t'(q.shift);
                            d.done = 1'b1;
                        end
                    end
                    if (sclk_fall) begin
                        d.fall_cnt = fall_next;
                        d.dout     = accel_word[accsp_pkg::ACCSP_TOP_BIT - fall_next];
                    end
                end
            end
            accsp_pkg::ACCSP_TEMP: begin
                if (q.sync2[accsp_pkg::ACCSP_LANE_TSEL]) begin
                    d.phase = accsp_pkg::ACCSP_IDLE;
                end else begin
                    if (sclk_rise) begin
                        d.rise_cnt = q.rise_cnt + 4'h1;
                        if (q.rise_cnt == accsp_pkg::ACCSP_LAST_EDGE) begin
                            d.phase = accsp_pkg::ACCSP_TEMP_HOLD;
                        end
                    end
                    if (sclk_fall) begin
                        d.fall_cnt = fall_next;
                        d.dout     = q.temp_word[accsp_pkg::ACCSP_TOP_BIT - fall_next];
                    end
                end
            end
            accsp_pkg::ACCSP_TEMP_HOLD: begin
                // last bit stays on the line until the select rises
                if (q.sync2[accsp_pkg::ACCSP_LANE_TSEL]) begin
                    d.phase = accsp_pkg::ACCSP_IDLE;
                end
            end
            default: begin
                d.phase = accsp_pkg::ACCSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q           <= '0;
            q.sync1     <= '1;
            q.sync2     <= '1;
            q.prev      <= '1;
            q.phase     <= accsp_pkg::ACCSP_IDLE;
            q.ctrl      <= accsp_pkg::accsp_ctrl_t'(accsp_pkg::ACCSP_CTRL_RESET);
        end else begin
            q <= d;
        end
    end

    assign dout_o          = q.dout;
    assign dout_oe_o       = (q.phase != accsp_pkg::ACCSP_IDLE);
    assign shutdown_o      = q.ctrl.power_mode_bit;
    assign axis_y_o        = q.ctrl.axis_select_bit;
    assign sample_strobe_o = q.strobe;
    assign conv_done_o     = q.done;
    assign sample_o        = q.sample;

    property p_start;
        @(posedge clk_i) disable iff (reset_i)
        (q.phase == accsp_pkg::ACCSP_IDLE && cs_fell && q.sync2[accsp_pkg::ACCSP_LANE_TSEL])
            |=> (dout_oe_o && q.rise_cnt == 4'h0 && !dout_o);
    endproperty
    a_start: assert property (p_start) else $error("accel frame did not start");

    property p_temp;
        @(posedge clk_i) disable iff (reset_i)
        (q.phase == accsp_pkg::ACCSP_IDLE && tsel_fell && q.sync2[accsp_pkg::ACCSP_LANE_CS])
            |=> (q.phase == accsp_pkg::ACCSP_TEMP && dout_oe_o);
    endproperty
    a_temp: assert property (p_temp) else $error("temp frame did not start");

    property p_release;
        @(posedge clk_i) disable iff (reset_i)
        (q.phase == accsp_pkg::ACCSP_ACCEL && q.sync2[accsp_pkg::ACCSP_LANE_CS])
            |=> !dout_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("output not released");

    property p_shift_out;
        @(posedge clk_i) disable iff (reset_i)
        ($changed(dout_o) && $past(dout_oe_o) && dout_oe_o) |-> $past(sclk_fall);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("data moved off falling edge");

    property p_capture;
        @(posedge clk_i) disable iff (reset_i)
        (q.phase == accsp_pkg::ACCSP_ACCEL && q.sync2[accsp_pkg::ACCSP_LANE_CS] == 1'b0 &&
         sclk_rise && q.rise_cnt < accsp_pkg::ACCSP_CTRL_EDGES)
            |=> q.shift == {$past(q.shift[6:0]), $past(q.sync2[accsp_pkg::ACCSP_LANE_DIN])};
    endproperty
    a_capture: assert property (p_capture) else $error("control bit not captured");

    property p_sample;
        @(posedge clk_i) disable iff (reset_i)
        sample_strobe_o |-> ($past(q.rise_cnt) == accsp_pkg::ACCSP_SAMPLE_EDGE &&
                             $past(sclk_rise) && !$past(shutdown_o) &&
                             q.rise_cnt == 4'h2 && sample_o == $past(axis_val));
    endproperty
    a_sample: assert property (p_sample) else $error("sample at wrong edge or value");

    property p_conv;
        @(posedge clk_i) disable iff (reset_i)
        conv_done_o |-> ($past(q.rise_cnt) == accsp_pkg::ACCSP_LAST_EDGE && q.rise_cnt == 4'h0 &&
                         q.ctrl == $past(q.shift));
    endproperty
    a_conv: assert property (p_conv) else $error("conversion end wrong");

    property p_continue;
        @(posedge clk_i) disable iff (reset_i)
        (conv_done_o && !q.sync2[accsp_pkg::ACCSP_LANE_CS])
            |-> (q.phase == accsp_pkg::ACCSP_ACCEL && dout_oe_o);
    endproperty
    a_continue: assert property (p_continue) else $error("no back-to-back conversion");

    property p_mode;
        @(posedge clk_i) disable iff (reset_i)
        $changed(shutdown_o) |-> $past(sclk_rise) && $past(q.rise_cnt) == accsp_pkg::ACCSP_LAST_EDGE;
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed off frame end");

    c_accel: cover property (@(posedge clk_i) disable iff (reset_i) conv_done_o);
    c_temp:  cover property (@(posedge clk_i) disable iff (reset_i)
                             q.phase == accsp_pkg::ACCSP_TEMP_HOLD);
    c_down:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(shutdown_o));

endmodule // accsp_port
`default_nettype wire
